// file: design/sst_fifo.sv
// sst_fifo: small synchronous fifo with valid/ready on both sides
// assumes: DEPTH is a power of two; in_ready_o comes from a flip-flop
`timescale 1ns/1ns
`default_nettype none

module sst_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 4
) (
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output var  logic         in_ready_o,
  output var  logic [W-1:0] out_data_o,
  output var  logic         out_valid_o,
  input  wire logic         out_ready_i
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic                    in_rdy;
  } sst_fifo_state_s;

  sst_fifo_state_s s;
  sst_fifo_state_s next_s;
  logic            push;
  logic            pop;

  assign push = in_valid_i && s.in_rdy;
  assign pop  = out_ready_i && (s.cnt != '0);

  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp        = PW'(s.wp + 1'b1);
    end
    if (pop)
      next_s.rp = PW'(s.rp + 1'b1);
    if (push && !pop)
      next_s.cnt = CW'(s.cnt + 1'b1);
    else if (pop && !push)
      next_s.cnt = CW'(s.cnt - 1'b1);
    next_s.in_rdy = (next_s.cnt != CW'(DEPTH));
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s        <= '0;
      s.in_rdy <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign in_ready_o  = s.in_rdy;
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o  = s.mem[s.rp];

endmodule : sst_fifo

`default_nettype wire

// file: design/sst_params.svh
// sst_params.svh: constants of the start/stop framed serdes
// assumes: included by bare name; widths fixed, counts in ref clock cycles or words
`ifndef SST_PARAMS_SVH
`define SST_PARAMS_SVH

// word and frame layout
`define SST_PAY_W        18
`define SST_FRM_W        20
`define SST_START_POS    0
`define SST_STOP_POS     19
`define SST_START_BIT    1'h1
`define SST_STOP_BIT     1'h0

// bit phase within a word, one bit per ref clock cycle
`define SST_BIT_LAST     5'h13
`define SST_HALF_WORD    5'h0a

// lock criteria, in words
`define SST_LOCK_WORDS   3'h4
`define SST_MISS_WORDS   3'h4
`define SST_HOLD_WORDS   4'h9

// sync request and pattern
`define SST_SYNC_MIN     3'h6
`define SST_SYNC_WORDS   11'h400
`define SST_SYNC_PAYLOAD 18'h001ff

// transmit buffer
`define SST_FIFO_DEPTH   4

`endif

// file: design/sst_pkg.sv
// sst_pkg: types of the start/stop framed serdes
// assumes: sst_params.svh is on the include path
`include "sst_params.svh"

package sst_pkg;

  typedef enum logic [3:0] {
    SST_RX_HUNT    = 4'h1,
    SST_RX_CONFIRM = 4'h2,
    SST_RX_LOCKED  = 4'h4,
    SST_RX_HOLD    = 4'h8
  } sst_rx_e;

  typedef logic [`SST_FRM_W-1:0] sst_frame_t;
  typedef logic [`SST_PAY_W-1:0] sst_pay_t;

  typedef struct packed {
    // transmit side
    logic [4:0]  tx_phase;
    sst_frame_t  tx_shift;
    logic        bit_clk;
    logic        word_clk;
    logic        ser_out;
    logic        ser_out_n;
    logic        ser_oe;
    logic        underrun;
    logic [2:0]  sync_hi;
    logic [10:0] sync_left;
    logic        sync_act;
    // receive side
    sst_rx_e     rx_state;
    sst_frame_t  rx_shift;
    logic [4:0]  rx_phase;
    logic [2:0]  good_cnt;
    logic [2:0]  miss_cnt;
    logic [3:0]  hold_cnt;
    sst_pay_t    rx_word;
    logic        rx_clk;
    logic        rx_oe;
    logic        lock_n;
  } sst_state_s;

endpackage : sst_pkg

// file: design/sst_serdes.sv
// sst_serdes: start/stop framed serialiser and deserialiser, word clock = ref_clk / 20
// assumes: one serial bit per ref_clk cycle; serial_in_i, sync_req_i, loopback_i are pins
//
// Contract
// - each word clock period outside a sync burst one buffered 18-bit word is captured; with none buffered a zero payload is sent and underrun set.
// - each 18-bit payload becomes a 20-bit frame with start and stop.
// - start bit is always one, stop bit is always zero.
// - an internal bit clock runs at ten times the word clock.
// - one serial bit on each edge of the bit clock.
// - payload bit zero goes first, higher bits in ascending order.
// - load-to-bit-zero delay is constant.
// - receiver deserialises frames into 20-bit words on the recovered word clock.
// - receiver strips start and stop, drives the 18 payload bits.
// - framing is invisible; host sees only 18-bit payloads.
// - loopback feeds the serialiser output into the deserialiser.
// - during reset recovered clock is low and serial outputs float.
// - lock only after four consecutive boundaries at the same position.
// - four consecutive misses drop lock, float outputs, hunt again.
// - sync pulse over six cycles sends 1024 words of sync pattern.
// - lock indicator stays inactive at least nine cycles after loss.
`timescale 1ns/1ns
`default_nettype none
`include "sst_params.svh"

module sst_serdes
  import sst_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 nrst_i,
  input  wire logic [`SST_PAY_W-1:0] tx_data_i,
  input  wire logic                 tx_valid_i,
  output var  logic                 tx_ready_o,
  output var  logic                 tx_underrun_o,
  output var  logic                 ref_word_clock_o,
  output var  logic                 serial_out_pos_o,
  output var  logic                 serial_out_neg_o,
  output var  logic                 serial_oe_o,
  input  wire logic                 serial_in_i,
  input  wire logic                 loopback_i,
  input  wire logic                 sync_req_i,
  output var  logic                 sync_active_o,
  output var  logic [`SST_PAY_W-1:0] rx_payload_word_o,
  output var  logic                 rx_word_clk_o,
  output var  logic                 rx_oe_o,
  output var  logic                 lock_indicator_n_o
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic sst_frame_t make_frame(input sst_pay_t pay);
    sst_frame_t f;
    f                 = {`SST_STOP_BIT, pay, `SST_START_BIT};
    return f;
  endfunction : make_frame

  function automatic logic frame_ok(input sst_frame_t f);
    return (f[`SST_START_POS] == `SST_START_BIT) && (f[`SST_STOP_POS] == `SST_STOP_BIT);
  endfunction : frame_ok

  ////////////////////////////////////////////////////////////////////////////////////////////
  // pins and transmit buffer

  sst_state_s         s;
  sst_state_s         next_s;
  logic [2:0]         pins_sync;
  logic               pin_serial;
  logic               pin_loop;
  logic               pin_sync;
  sst_pay_t           fifo_data;
  logic               fifo_valid;
  logic               fifo_take;
  logic               tick;
  logic               sync_fire;
  sst_frame_t         frame;
  logic               rx_bit;
  sst_frame_t         rx_next_sr;
  logic               rx_end;

  sst_sync2 #(
    .W (3)
  ) u_pins (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .async_i   ({sync_req_i, loopback_i, serial_in_i}),
    .sync_o    (pins_sync)
  );

  assign pin_serial = pins_sync[0];
  assign pin_loop   = pins_sync[1];
  assign pin_sync   = pins_sync[2];

  // words wait here while a sync burst holds the shifter
  sst_fifo #(
    .W     (`SST_PAY_W),
    .DEPTH (`SST_FIFO_DEPTH)
  ) u_txq (
    .ref_clk_i   (ref_clk_i),
    .nrst_i      (nrst_i),
    .in_data_i   (tx_data_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_take)
  );

  assign tick      = (s.tx_phase == `SST_BIT_LAST);
  assign fifo_take = tick && (s.sync_left == '0);
  assign sync_fire = pin_sync && (s.sync_hi == `SST_SYNC_MIN);
  assign frame     = (s.sync_left != '0) ? make_frame(`SST_SYNC_PAYLOAD) :
                     fifo_valid ? make_frame(fifo_data) : make_frame('0);
  assign rx_bit     = pin_loop ? s.ser_out : pin_serial;
  assign rx_next_sr = {rx_bit, s.rx_shift[`SST_FRM_W-1:1]};
  assign rx_end     = (s.rx_phase == `SST_BIT_LAST);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_s = s;

    // transmit: bit clock toggles every cycle, so every cycle is one of its edges
    next_s.bit_clk  = ~s.bit_clk;
    next_s.tx_phase = tick ? 5'h00 : 5'(s.tx_phase + 5'h01);
    if (tick)
    begin
      next_s.ser_out  = frame[0];
      next_s.tx_shift = {1'b0, frame[`SST_FRM_W-1:1]};
      next_s.underrun = (s.sync_left == '0) && !fifo_valid;
    end
    else
    begin
      next_s.ser_out  = s.tx_shift[0];
      next_s.tx_shift = {1'b0, s.tx_shift[`SST_FRM_W-1:1]};
    end
    next_s.ser_out_n = ~next_s.ser_out;
    next_s.ser_oe    = 1'b1;
    next_s.word_clk  = (next_s.tx_phase < `SST_HALF_WORD);

    // sync request: width filter, one burst per pulse
    if (!pin_sync)
      next_s.sync_hi = 3'h0;
    else if (s.sync_hi != 3'h7)
      next_s.sync_hi = 3'(s.sync_hi + 3'h1);
    if (sync_fire)
      next_s.sync_left = `SST_SYNC_WORDS;
    else if (tick && (s.sync_left != '0))
      next_s.sync_left = 11'(s.sync_left - 11'h001);
    next_s.sync_act = (next_s.sync_left != '0);

    // receive: boundary hunt and lock keeping
    next_s.rx_shift = rx_next_sr;
    next_s.rx_phase = rx_end ? 5'h00 : 5'(s.rx_phase + 5'h01);
    unique case (s.rx_state)
      SST_RX_HUNT:
      begin
        if (frame_ok(rx_next_sr))
        begin
          next_s.rx_state = SST_RX_CONFIRM;
          next_s.good_cnt = 3'h1;
          next_s.rx_phase = 5'h00;
        end
      end
      SST_RX_CONFIRM:
      begin
        if (rx_end)
        begin
          if (!frame_ok(rx_next_sr))
            next_s.rx_state = SST_RX_HUNT;
          else if (s.good_cnt == 3'(`SST_LOCK_WORDS - 3'h1))
          begin
            next_s.rx_state = SST_RX_LOCKED;
            next_s.miss_cnt = 3'h0;
            next_s.rx_word  = rx_next_sr[`SST_PAY_W:1];
          end
          else
            next_s.good_cnt = 3'(s.good_cnt + 3'h1);
        end
      end
      SST_RX_LOCKED:
      begin
        if (rx_end)
        begin
          if (frame_ok(rx_next_sr))
          begin
            next_s.miss_cnt = 3'h0;
            next_s.rx_word  = rx_next_sr[`SST_PAY_W:1];
          end
          else if (s.miss_cnt == 3'(`SST_MISS_WORDS - 3'h1))
          begin
            next_s.rx_state = SST_RX_HOLD;
            next_s.hold_cnt = 4'h0;
          end
          else
            next_s.miss_cnt = 3'(s.miss_cnt + 3'h1);
        end
      end
      SST_RX_HOLD:
      begin
        if (rx_end)
        begin
          if (s.hold_cnt == 4'(`SST_HOLD_WORDS - 4'h1))
            next_s.rx_state = SST_RX_HUNT;
          else
            next_s.hold_cnt = 4'(s.hold_cnt + 4'h1);
        end
      end
      default:
        next_s.rx_state = SST_RX_HUNT;
    endcase

    // outputs float and clock sits low whenever not locked
    next_s.lock_n = (next_s.rx_state != SST_RX_LOCKED);
    next_s.rx_oe  = !next_s.lock_n;
    next_s.rx_clk = !next_s.lock_n && (next_s.rx_phase >= `SST_HALF_WORD);
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s          <= '0;
      s.tx_phase <= `SST_BIT_LAST;
      s.rx_state <= SST_RX_HUNT;
      s.lock_n   <= 1'h1;
    end
    else
      s <= next_s;
  end

  assign tx_underrun_o      = s.underrun;
  assign ref_word_clock_o   = s.word_clk;
  assign serial_out_pos_o   = s.ser_out;
  assign serial_out_neg_o   = s.ser_out_n;
  assign serial_oe_o        = s.ser_oe;
  assign sync_active_o      = s.sync_act;
  assign rx_payload_word_o  = s.rx_word;
  assign rx_word_clk_o      = s.rx_clk;
  assign rx_oe_o            = s.rx_oe;
  assign lock_indicator_n_o = s.lock_n;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence frame_head_seq;
    tick && fifo_take && fifo_valid;
  endsequence

  sequence start_then_d0_seq;
    (serial_out_pos_o == `SST_START_BIT) ##1 (serial_out_pos_o == $past(fifo_data[0], 2));
  endsequence

  start_bit_a : assert property (
    (s.tx_phase == 5'h00) && serial_oe_o |-> serial_out_pos_o == `SST_START_BIT)
    else $error("start bit not one");

  stop_bit_a : assert property (
    (s.tx_phase == `SST_BIT_LAST) && serial_oe_o |-> serial_out_pos_o == `SST_STOP_BIT)
    else $error("stop bit not zero");

  payload_order_a : assert property (
    frame_head_seq |=> start_then_d0_seq)
    else $error("payload bit zero not after start bit");

  // reset released on an edge: state first moves one edge later
  bit_clock_a : assert property (
    $past(nrst_i) |-> s.bit_clk != $past(s.bit_clk))
    else $error("bit clock did not toggle");

  word_period_a : assert property (
    tick && $past(nrst_i) |-> ##20 tick)
    else $error("word period not twenty cycles");

  pair_compl_a : assert property (
    serial_oe_o |-> serial_out_neg_o == !serial_out_pos_o)
    else $error("serial pair not complementary");

  lock_entry_a : assert property (
    $fell(lock_indicator_n_o) |-> $past(s.rx_state) == SST_RX_CONFIRM
                                  && $past(s.good_cnt) == 3'h3)
    else $error("lock without four boundaries");

  lock_hold_a : assert property (
    $rose(lock_indicator_n_o) |-> ##1 lock_indicator_n_o [*8])
    else $error("lock indicator active too soon");

  float_unlocked_a : assert property (
    lock_indicator_n_o |-> !rx_oe_o && !rx_word_clk_o)
    else $error("outputs driven while unlocked");

  sync_burst_a : assert property (
    sync_fire |-> ##[1:20] (tick && s.sync_act) ##1 (serial_out_pos_o == `SST_START_BIT)
                  ##1 serial_out_pos_o [*8] ##1 serial_out_pos_o)
    else $error("sync pattern not sent");

endmodule : sst_serdes

`default_nettype wire

// file: design/sst_sync2.sv
// sst_sync2: two flip-flop synchroniser for asynchronous level inputs
// assumes: inputs are slow levels; outputs are read only after the second stage
`timescale 1ns/1ns
`default_nettype none

module sst_sync2 #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sst_sync_state_s;

  sst_sync_state_s s;
  sst_sync_state_s next_s;

  always_comb
  begin
    next_s.stage1 = async_i;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign sync_o = s.stage2;

endmodule : sst_sync2

`default_nettype wire

// file: tb/sst_link_partner.sv
// sst_link_partner: far-end serialiser feeding the serial input pin
// assumes: shares the 10 MHz clock; one bit per cycle, frames back to back
`timescale 1ns/1ns
`default_nettype none

module sst_link_partner (
  input  wire logic        ref_clk_i,
  input  wire logic        send_i,
  input  wire logic        corrupt_i,
  input  wire logic [17:0] payload_i,
  output var  logic        serial_o
);
  logic [4:0]  phase;
  logic [19:0] frame;

  initial
  begin
    phase    = 5'h00;
    serial_o = 1'b0;
  end

  // corrupt drops the start bit so the boundary no longer matches
  always_comb frame = {1'b0, payload_i, ~corrupt_i};

  // line parked low while not sending
  always @(posedge ref_clk_i)
  begin
    if (!send_i)
    begin
      phase    <= 5'h00;
      serial_o <= 1'b0;
    end
    else
    begin
      serial_o <= frame[phase];
      phase    <= (phase == 5'h13) ? 5'h00 : phase + 5'h01;
    end
  end
endmodule : sst_link_partner

`default_nettype wire

// file: tb/start_stop_framed_serdes_tb_top.sv
// start_stop_framed_serdes_tb_top: self-checking bench for sst_serdes
// assumes: design files and sst_link_partner compiled first
`timescale 1ns/1ns
`default_nettype none

module start_stop_framed_serdes_tb_top
  import sst_pkg::*;
;
  logic        ref_clk, nrst, tx_valid, loopback, sync_req;
  logic        p_send, p_corrupt, p_line;
  sst_pay_t    tx_data, p_payload, rx_payload_word_o;
  logic        tx_ready_o, tx_underrun_o, ref_word_clock_o, sync_active_o;
  logic        serial_out_pos_o, serial_out_neg_o, serial_oe_o;
  logic        rx_word_clk_o, rx_oe_o, lock_indicator_n_o;
  wire  [17:0] rx_pins = rx_oe_o ? rx_payload_word_o : 18'hzzzzz;
  int          fail_count, checks_done, last_wait;

  sst_serdes DUT (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready_o), .tx_underrun_o(tx_underrun_o),
    .ref_word_clock_o(ref_word_clock_o), .serial_out_pos_o(serial_out_pos_o),
    .serial_out_neg_o(serial_out_neg_o), .serial_oe_o(serial_oe_o),
    .serial_in_i(p_line), .loopback_i(loopback), .sync_req_i(sync_req),
    .sync_active_o(sync_active_o), .rx_payload_word_o(rx_payload_word_o),
    .rx_word_clk_o(rx_word_clk_o), .rx_oe_o(rx_oe_o),
    .lock_indicator_n_o(lock_indicator_n_o)
  );

  sst_link_partner PARTNER (
    .ref_clk_i(ref_clk), .send_i(p_send), .corrupt_i(p_corrupt),
    .payload_i(p_payload), .serial_o(p_line)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(string what, logic exp, logic got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_vec(string what, logic [19:0] exp, logic [19:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_vec

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic timed_out(string what);
    fail_count++;
    $display("CHECK FAILED %s expected event seen timeout", what);
    complete_run();
  endtask : timed_out

  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // hold valid until ready seen, release at the taking edge
  task automatic push(sst_pay_t w);
    @(posedge ref_clk);
    tx_data  <= w;
    tx_valid <= 1'b1;
    #1;
    for (last_wait = 0; last_wait < 200 && tx_ready_o !== 1'b1; last_wait++)
      tick(1);
    if (last_wait == 200)
      timed_out("tx_ready_o");
    @(posedge ref_clk);
    tx_valid <= 1'b0;
    #1;
  endtask : push

  task automatic wait_lock(logic lvl, int lim);
    int n;
    for (n = 0; n < lim && lock_indicator_n_o !== lvl; n++)
      tick(1);
    if (n == lim)
      timed_out("lock_indicator_n_o");
  endtask : wait_lock

  task automatic wait_rx(sst_pay_t w, int lim);
    int n;
    for (n = 0; n < lim && rx_pins !== w; n++)
      tick(1);
    if (n == lim)
      timed_out("rx_payload_word_o");
    chk_vec("rx payload", {2'b00, w}, {2'b00, rx_pins});
  endtask : wait_rx

  // frame starts where the word clock rises
  task automatic get_frame(output logic [19:0] f);
    logic prev;
    int   n;
    prev = 1'b1;
    for (n = 0; n < 60 && !(ref_word_clock_o === 1'b1 && prev === 1'b0); n++)
    begin
      prev = ref_word_clock_o;
      tick(1);
    end
    if (n == 60)
      timed_out("ref_word_clock_o");
    for (n = 0; n < 20; n++)
    begin
      if (n > 0)
        tick(1);
      f[n] = serial_out_pos_o;
      chk_bit("serial neg", ~serial_out_pos_o, serial_out_neg_o);
    end
  endtask : get_frame

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    tick(2);
    chk_bit("serial oe", 1'b0, serial_oe_o);
    chk_bit("rx word clk", 1'b0, rx_word_clk_o);
    chk_bit("lock n", 1'b1, lock_indicator_n_o);
    $display("test reset done");
  endtask : test_reset

  task automatic test_partner_lock;
    int hi;
    @(posedge ref_clk);
    // one rising edge per frame, so no false boundary on relock
    p_payload <= 18'h0003f;
    p_send    <= 1'b1;
    tick(60);
    chk_bit("early lock n", 1'b1, lock_indicator_n_o);
    chk_bit("rx clk unlocked", 1'b0, rx_word_clk_o);
    chk_bit("tx underrun", 1'b1, tx_underrun_o);
    wait_lock(1'b0, 300);
    wait_rx(18'h0003f, 60);
    hi = 0;
    repeat (20)
    begin
      tick(1);
      if (rx_word_clk_o === 1'b1)
        hi++;
    end
    chk_bit("rx clk duty", 1'b1, hi == 10);
    @(posedge ref_clk);
    p_corrupt <= 1'b1;
    wait_lock(1'b1, 150);
    tick(1);
    chk_bit("rx oe lost", 1'b0, rx_oe_o);
    chk_bit("rx clk lost", 1'b0, rx_word_clk_o);
    chk_vec("rx float", {2'b00, 18'hzzzzz}, {2'b00, rx_pins});
    repeat (9)
    begin
      tick(1);
      chk_bit("lock hold", 1'b1, lock_indicator_n_o);
    end
    @(posedge ref_clk);
    p_corrupt <= 1'b0;
    wait_lock(1'b0, 600);
    wait_rx(18'h0003f, 60);
    $display("test partner lock done");
  endtask : test_partner_lock

  task automatic test_loop_fifo;
    @(posedge ref_clk);
    p_send   <= 1'b0;
    loopback <= 1'b1;
    wait_lock(1'b1, 200);
    wait_lock(1'b0, 800);
    fork
      begin
        for (int i = 0; i < 6; i++)
        begin
          push(18'h10101 + 18'(i));
          if (i == 5)
            chk_bit("fifo refused", 1'b1, last_wait > 0);
        end
      end
      for (int i = 0; i < 6; i++)
        wait_rx(18'h10101 + 18'(i), 120);
    join
    $display("test loopback fifo done");
  endtask : test_loop_fifo

  task automatic test_tx_frame;
    logic [19:0] f;
    push(18'h3c96a);
    for (int i = 0; i < 3; i++)
    begin
      get_frame(f);
      if (f[18:1] !== 18'h00000)
        break;
    end
    chk_vec("tx frame", {1'b0, 18'h3c96a, 1'b1}, f);
    chk_bit("serial oe", 1'b1, serial_oe_o);
    $display("test tx frame done");
  endtask : test_tx_frame

  task automatic test_sync;
    logic [19:0] f;
    int          n;
    @(posedge ref_clk);
    sync_req <= 1'b1;
    repeat (6) @(posedge ref_clk);
    sync_req <= 1'b0;
    tick(15);
    chk_bit("short sync", 1'b0, sync_active_o);
    @(posedge ref_clk);
    sync_req <= 1'b1;
    repeat (8) @(posedge ref_clk);
    sync_req <= 1'b0;
    tick(4);
    chk_bit("sync active", 1'b1, sync_active_o);
    get_frame(f);
    chk_vec("sync frame", {1'b0, 18'h001ff, 1'b1}, f);
    for (n = 0; n < 21000 && sync_active_o === 1'b1; n++)
      tick(1);
    if (n == 21000)
      timed_out("sync_active_o");
    chk_bit("sync length", 1'b1, n > 20400 && n < 20500);
    $display("test sync done");
  endtask : test_sync

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    fail_count  = 0;
    checks_done = 0;
    nrst        = 1'b0;
    tx_data     = 18'h00000;
    tx_valid    = 1'b0;
    loopback    = 1'b0;
    sync_req    = 1'b0;
    p_send      = 1'b0;
    p_corrupt   = 1'b0;
    p_payload   = 18'h00000;
    test_reset();
    @(posedge ref_clk);
    nrst <= 1'b1;
    test_partner_lock();
    test_loop_fifo();
    test_tx_frame();
    test_sync();
    complete_run();
  end
endmodule : start_stop_framed_serdes_tb_top

`default_nettype wire
